//--- verilog/pvfm_pkg.sv
// package of constants and types for the pfc voltage-loop fast mode block
package pvfm_pkg;

    // ==========================================================
    // register addresses
    localparam logic [15:0] ADDR_DITHER = 16'hFE1D;
    localparam logic [15:0] ADDR_SYNC = 16'hFE1E;
    localparam logic [15:0] ADDR_NGAIN = 16'hFE20;
    localparam logic [15:0] ADDR_NZERO = 16'hFE21;
    localparam logic [15:0] ADDR_FGAIN = 16'hFE22;
    localparam logic [15:0] ADDR_FZERO = 16'hFE23;
    localparam logic [15:0] ADDR_FCTL = 16'hFE24;

    // ==========================================================
    // reset values and field layout
    localparam logic [7:0] REG_RESET = 8'h00;
    localparam logic [7:0] DITHER_MASK = 8'h7F;
    localparam int unsigned DITHER_W = 7;
    localparam int unsigned SYNC_LSB = 0;
    localparam int unsigned CTL_LINE_BIT = 7;
    localparam int unsigned CTL_BAND_LSB = 5;
    localparam int unsigned CTL_DELAY_LSB = 2;
    localparam int unsigned CTL_SS_BIT = 1;
    localparam int unsigned CTL_DLY_EN_BIT = 0;
    localparam logic [2:0] DELAY_ZERO = 3'h0;
    localparam logic [2:0] DELAY_ONE = 3'h1;

    // band codes: 0 = 1.5625%, 1 = 3.125%, 2 = 6.25%, 3 = 12.5%
    typedef enum logic [1:0] {
        PVFM_BAND_1P56 = 2'h0,
        PVFM_BAND_3P13 = 2'h1,
        PVFM_BAND_6P25 = 2'h2,
        PVFM_BAND_12P5 = 2'h3
    } pvfm_band_t;

    // ==========================================================
    // timing
    localparam int unsigned CLK_PERIOD_NS = 25;
    localparam int unsigned DITHER_LSB_NS = 40000;
    localparam int unsigned DITHER_LSB_CYCLES = DITHER_LSB_NS / CLK_PERIOD_NS;
    localparam int unsigned PRESCALE_W = 11;
    localparam logic [PRESCALE_W-1:0] PRESCALE_LAST = PRESCALE_W'(DITHER_LSB_CYCLES - 1);

    // ==========================================================
    // carriers
    typedef struct packed {
        logic wr;
        logic rd;
        logic [15:0] addr;
        logic [7:0] wdata;
    } pvfm_reg_req_t;

    typedef struct packed {
        logic [7:0] gain;
        logic [7:0] zero;
    } pvfm_coef_t;

    typedef enum logic [2:0] {
        PVFM_ST_NORMAL = 3'b001,
        PVFM_ST_FAST = 3'b010,
        PVFM_ST_HOLD = 3'b100
    } pvfm_state_t;

endpackage

//--- verilog/pvfm_dither_timer.sv
// dither update timer: one-cycle tick every period x 40 us
module pvfm_dither_timer (
    input wire logic mclk,
    input wire logic rstn,
    input wire logic [pvfm_pkg::DITHER_W-1:0] period,
    output logic tick
);

    typedef struct packed {
        logic [pvfm_pkg::PRESCALE_W-1:0] pre;
        logic [pvfm_pkg::DITHER_W-1:0] units;
        logic tick;
    } pvfm_dt_state_t;

    pvfm_dt_state_t s_q;
    pvfm_dt_state_t s_d;

    // ==========================================================
    // counting
    always_comb begin
        s_d = s_q;
        s_d.tick = 1'b0;
        // zero period: dithering halted, counters parked
        if (period == '0) begin
            s_d.pre = '0;
            s_d.units = '0;
        end else if (s_q.pre == pvfm_pkg::PRESCALE_LAST) begin
            s_d.pre = '0;
            if (s_q.units >= period - 7'h01) begin
                s_d.units = '0;
                s_d.tick = 1'b1;
            end else begin
                s_d.units = s_q.units + 7'h01;
            end
        end else begin
            s_d.pre = s_q.pre + 11'h001;
        end
    end

    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign tick = s_q.tick;

endmodule

//--- verilog/pvfm_top.sv
// voltage-loop coefficient registers and normal/fast filter selection
module pvfm_top (
    input wire logic mclk,
    input wire logic rstn,
    input pvfm_pkg::pvfm_reg_req_t reg_req,
    output logic [7:0] reg_rdata,
    output logic reg_rvalid,
    input wire logic overshoot_flag,
    input wire logic band_error_flag,
    input wire logic soft_start,
    input wire logic half_cycle_tick,
    output pvfm_pkg::pvfm_band_t band_sel,
    output logic fast_mode,
    output pvfm_pkg::pvfm_coef_t vloop_coef,
    output logic dither_tick,
    output logic [2:0] sync_divisor
);

    // ==========================================================
    // local types and state
    typedef struct packed {
        logic [7:0] dither;
        logic [7:0] sync;
        logic [7:0] ngain;
        logic [7:0] nzero;
        logic [7:0] fgain;
        logic [7:0] fzero;
        logic [7:0] fctl;
        pvfm_pkg::pvfm_state_t st;
        logic [2:0] hold_cnt;
        pvfm_pkg::pvfm_coef_t coef;
        logic [7:0] rdata;
        logic rvalid;
    } pvfm_top_state_t;

    pvfm_top_state_t s_q;
    pvfm_top_state_t s_d;

    logic line_trig;
    logic delayed_trig;
    logic [2:0] delay_code;
    logic back_in_band;
    logic any_trig;

    // ==========================================================
    // register read decode
    function automatic logic [7:0] reg_read(input logic [15:0] addr, input pvfm_top_state_t s);
        logic [7:0] v;
        v = 8'h00;
        unique case (addr)
            pvfm_pkg::ADDR_DITHER: v = s.dither & pvfm_pkg::DITHER_MASK;
            pvfm_pkg::ADDR_SYNC: v = s.sync;
            pvfm_pkg::ADDR_NGAIN: v = s.ngain;
            pvfm_pkg::ADDR_NZERO: v = s.nzero;
            pvfm_pkg::ADDR_FGAIN: v = s.fgain;
            pvfm_pkg::ADDR_FZERO: v = s.fzero;
            pvfm_pkg::ADDR_FCTL: v = s.fctl;
            default: v = 8'h00;
        endcase
        return v;
    endfunction

    // ==========================================================
    // register write decode
    // unmapped addresses leave every register as it was
    function automatic pvfm_top_state_t reg_write(input pvfm_top_state_t s, input logic [15:0] addr,
        input logic [7:0] d);
        pvfm_top_state_t n;
        n = s;
        unique case (addr)
            pvfm_pkg::ADDR_DITHER: n.dither = d & pvfm_pkg::DITHER_MASK;
            pvfm_pkg::ADDR_SYNC: n.sync = d;
            pvfm_pkg::ADDR_NGAIN: n.ngain = d;
            pvfm_pkg::ADDR_NZERO: n.nzero = d;
            pvfm_pkg::ADDR_FGAIN: n.fgain = d;
            pvfm_pkg::ADDR_FZERO: n.fzero = d;
            pvfm_pkg::ADDR_FCTL: n.fctl = d;
            default: n = s;
        endcase
        return n;
    endfunction

    // ==========================================================
    // coefficient set selection
    // gain and zero always come from one set, never mixed
    function automatic pvfm_pkg::pvfm_coef_t pick_coef(input logic fast, input pvfm_top_state_t s);
        pvfm_pkg::pvfm_coef_t c;
        if (fast) begin
            c.gain = s.fgain;
            c.zero = s.fzero;
        end else begin
            c.gain = s.ngain;
            c.zero = s.nzero;
        end
        return c;
    endfunction

    // ==========================================================
    // trigger decode
    // overshoot path is gated only by its enable, so it acts at once
    assign line_trig = s_q.fctl[pvfm_pkg::CTL_LINE_BIT] & overshoot_flag;
    // band error path adds no delay beyond the register stage
    assign delayed_trig = s_q.fctl[pvfm_pkg::CTL_DLY_EN_BIT] & band_error_flag;
    assign delay_code = s_q.fctl[pvfm_pkg::CTL_DELAY_LSB +: 3];
    // leaving fast mode needs the error inside the band and no overshoot while the overshoot enable is set
    assign back_in_band = !band_error_flag && !line_trig;
    assign any_trig = line_trig || delayed_trig;

    // ==========================================================
    // next state
    always_comb begin
        s_d = s_q;
        s_d.rvalid = 1'b0;
        if (reg_req.wr) begin
            s_d = reg_write(s_d, reg_req.addr, reg_req.wdata);
        end
        if (reg_req.rd) begin
            s_d.rdata = reg_read(reg_req.addr, s_q);
            s_d.rvalid = 1'b1;
        end

        // soft start overrides the transient machine outright
        if (soft_start) begin
            s_d.hold_cnt = pvfm_pkg::DELAY_ZERO;
            if (s_q.fctl[pvfm_pkg::CTL_SS_BIT]) begin
                s_d.st = pvfm_pkg::PVFM_ST_FAST;
            end else begin
                s_d.st = pvfm_pkg::PVFM_ST_NORMAL;
            end
        end else begin
            unique case (s_q.st)
                pvfm_pkg::PVFM_ST_NORMAL: begin
                    if (any_trig) begin
                        s_d.st = pvfm_pkg::PVFM_ST_FAST;
                    end
                end
                pvfm_pkg::PVFM_ST_FAST: begin
                    // exit only once the error is back inside the band
                    if (back_in_band) begin
                        if (delay_code == pvfm_pkg::DELAY_ZERO) begin
                            s_d.st = pvfm_pkg::PVFM_ST_NORMAL;
                        end else begin
                            // count reloads from the code on every fresh exit
                            s_d.st = pvfm_pkg::PVFM_ST_HOLD;
                            s_d.hold_cnt = delay_code;
                        end
                    end
                end
                pvfm_pkg::PVFM_ST_HOLD: begin
                    // a new trigger cancels the countdown
                    if (any_trig) begin
                        s_d.st = pvfm_pkg::PVFM_ST_FAST;
                    end else if (half_cycle_tick) begin
                        if (s_q.hold_cnt <= pvfm_pkg::DELAY_ONE) begin
                            s_d.st = pvfm_pkg::PVFM_ST_NORMAL;
                            s_d.hold_cnt = pvfm_pkg::DELAY_ZERO;
                        end else begin
                            s_d.hold_cnt = s_q.hold_cnt - 3'h1;
                        end
                    end
                end
                default: s_d.st = pvfm_pkg::PVFM_ST_NORMAL;
            endcase
        end

        // coefficient set follows the mode chosen this cycle
        s_d.coef = pick_coef(s_d.st != pvfm_pkg::PVFM_ST_NORMAL, s_d);
    end

    // ==========================================================
    // state register
    // all registers clear to zero and the state resets to normal, so reset leaves the normal set selected
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            s_q.dither <= pvfm_pkg::REG_RESET;
            s_q.sync <= pvfm_pkg::REG_RESET;
            s_q.ngain <= pvfm_pkg::REG_RESET;
            s_q.nzero <= pvfm_pkg::REG_RESET;
            s_q.fgain <= pvfm_pkg::REG_RESET;
            s_q.fzero <= pvfm_pkg::REG_RESET;
            s_q.fctl <= pvfm_pkg::REG_RESET;
            s_q.st <= pvfm_pkg::PVFM_ST_NORMAL;
            s_q.hold_cnt <= pvfm_pkg::DELAY_ZERO;
            s_q.coef <= '0;
            s_q.rdata <= 8'h00;
            s_q.rvalid <= 1'b0;
        end else begin
            s_q <= s_d;
        end
    end

    // ==========================================================
    // dither timer
    // zero period parks the timer, so no ticks come out
    pvfm_dither_timer u_dither (
        .mclk(mclk),
        .rstn(rstn),
        .period(s_q.dither[pvfm_pkg::DITHER_W-1:0]),
        .tick(dither_tick)
    );

    // ==========================================================
    // outputs
    assign reg_rdata = s_q.rdata;
    assign reg_rvalid = s_q.rvalid;
    assign band_sel = pvfm_pkg::pvfm_band_t'(s_q.fctl[pvfm_pkg::CTL_BAND_LSB +: 2]);
    // decoded straight from the state register, so it cannot glitch on flag edges
    assign fast_mode = s_q.st != pvfm_pkg::PVFM_ST_NORMAL;
    assign vloop_coef = s_q.coef;
    // divisor n means fsw = fsync / n
    assign sync_divisor = {1'b0, s_q.sync[pvfm_pkg::SYNC_LSB +: 2]} + 3'h1;

endmodule

//--- test/pvfm_chk.sv
// checker for the pfc voltage-loop fast mode block
module pvfm_chk (
    input wire logic mclk,
    input wire logic rstn,
    input pvfm_pkg::pvfm_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid,
    input wire logic overshoot_flag,
    input wire logic band_error_flag,
    input wire logic soft_start,
    input wire logic half_cycle_tick,
    input pvfm_pkg::pvfm_band_t band_sel,
    input wire logic fast_mode,
    input pvfm_pkg::pvfm_coef_t vloop_coef,
    input wire logic dither_tick,
    input wire logic [2:0] sync_divisor
);
    // ==========================================================
    // shadow of the register file, indexed by the low address nibble
    logic [15:0][7:0] r_q;
    always_ff @(posedge mclk or negedge rstn) begin
        if (!rstn) begin
            r_q <= '0;
        end else if (reg_req.wr) begin
            r_q[reg_req.addr[3:0]] <= reg_req.wdata;
        end
    end
    default clocking @(posedge mclk); endclocking
    default disable iff (!rstn);
    property p_rvalid; reg_req.rd |=> reg_rvalid; endproperty
    property p_line; !soft_start && r_q[4][7] && overshoot_flag |=> fast_mode; endproperty
    property p_dly; !soft_start && r_q[4][0] && band_error_flag |=> fast_mode; endproperty
    property p_ss; soft_start |=> fast_mode == $past(r_q[4][1]); endproperty
    property p_band; band_sel == r_q[4][6:5]; endproperty
    // coef follows writes to the active set at the same edge as the register itself
    property p_coef_f; fast_mode |-> vloop_coef == {r_q[2], r_q[3]}; endproperty
    property p_coef_n; !fast_mode |-> vloop_coef == {r_q[0], r_q[1]}; endproperty
    property p_exit;
        fast_mode && !band_error_flag && !overshoot_flag && !soft_start && r_q[4][4:2] == 3'h0 |=> !fast_mode;
    endproperty
    a_rvalid: assert property (p_rvalid) else $error("read without valid");
    a_line: assert property (p_line) else $error("overshoot missed");
    a_dly: assert property (p_dly) else $error("band error missed");
    a_ss: assert property (p_ss) else $error("soft start filter wrong");
    a_band: assert property (p_band) else $error("band code wrong");
    a_coef_f: assert property (p_coef_f) else $error("fast set wrong");
    a_coef_n: assert property (p_coef_n) else $error("normal set wrong");
    a_exit: assert property (p_exit) else $error("no zero-delay exit");
    c_fast: cover property ($rose(fast_mode));
    c_tick: cover property (dither_tick);
    c_ss: cover property (soft_start && fast_mode);
endmodule

bind pvfm_top pvfm_chk chk_u (.mclk(mclk), .rstn(rstn), .reg_req(reg_req), .reg_rdata(reg_rdata),
    .reg_rvalid(reg_rvalid), .overshoot_flag(overshoot_flag), .band_error_flag(band_error_flag),
    .soft_start(soft_start), .half_cycle_tick(half_cycle_tick), .band_sel(band_sel), .fast_mode(fast_mode),
    .vloop_coef(vloop_coef), .dither_tick(dither_tick), .sync_divisor(sync_divisor));

//--- test/pvfm_host.sv
// management bus host model driving the register port
module pvfm_host (
    input wire logic mclk,
    output pvfm_pkg::pvfm_reg_req_t reg_req,
    input wire logic [7:0] reg_rdata,
    input wire logic reg_rvalid
);
    timeunit 1ns;
    timeprecision 1ps;
    initial reg_req = '0;
    // ==========================================================
    // released lines show the inverse, so stale values never pass
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        @(negedge mclk);
        reg_req = '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(negedge mclk);
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: ~d};
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] d, output logic ok);
        @(negedge mclk);
        reg_req = '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
        @(negedge mclk);
        reg_req = '{wr: 1'b0, rd: 1'b0, addr: ~a, wdata: 8'hFF};
        ok = reg_rvalid;
        d = reg_rdata;
    endtask
endmodule

//--- test/tb_top.sv
// self-checking testbench for the pfc voltage-loop fast mode block
module tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0;
    logic rstn = 1'b0;
    logic ov = 1'b0, be = 1'b0, ss = 1'b0, ht = 1'b0, rvalid, ok, fm, tick;
    logic [7:0] rdata, rv;
    logic [2:0] sdiv;
    pvfm_pkg::pvfm_reg_req_t req;
    pvfm_pkg::pvfm_band_t band;
    pvfm_pkg::pvfm_coef_t coef;
    int err_count = 0, checked = 0, n;
    always #12.5 mclk = ~mclk;
    pvfm_top dut_u (.mclk(mclk), .rstn(rstn), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid),
        .overshoot_flag(ov), .band_error_flag(be), .soft_start(ss), .half_cycle_tick(ht), .band_sel(band),
        .fast_mode(fm), .vloop_coef(coef), .dither_tick(tick), .sync_divisor(sdiv));
    pvfm_host host_u (.mclk(mclk), .reg_req(req), .reg_rdata(rdata), .reg_rvalid(rvalid));
    // ==========================================================
    // shared helpers
    task automatic chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        checked++;
        if (g !== e) begin
            err_count++;
            $display("unexpected %s: expected %h seen %h", nm, e, g);
        end
    endtask
    task automatic close_out;
        $display("comparisons %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask
    task automatic rchk(input logic [15:0] a, input logic [7:0] e);
        host_u.rd(a, rv, ok);
        chk("rvalid", 16'h0001, {15'h0000, ok});
        chk("rdata", {8'h00, e}, {8'h00, rv});
    endtask
    task automatic step(input int c);
        repeat (c) @(negedge mclk);
    endtask
    // ==========================================================
    // scenarios
    task automatic s_regs;
        logic [15:0] a [8] = '{16'hFE1D, 16'hFE1E, 16'hFE20, 16'hFE21, 16'hFE22, 16'hFE23, 16'hFE24, 16'hFE1F};
        for (int i = 0; i < 8; i++) rchk(a[i], 8'h00);
        for (int i = 0; i < 8; i++) host_u.wr(a[i], 8'hF0 + 8'(i));
        // top bit of the dither period is dropped; the unmapped place reads zero
        for (int i = 0; i < 8; i++) rchk(a[i], i == 0 ? 8'h70 : i == 7 ? 8'h00 : 8'hF0 + 8'(i));
    endtask
    task automatic s_fields;
        for (int c = 0; c < 4; c++) begin
            host_u.wr(16'hFE1E, 8'(c));
            host_u.wr(16'hFE24, 8'(c << 5));
            chk("sync_divisor", 16'(c + 1), {13'h0000, sdiv});
            chk("band_sel", 16'(c), {14'h0000, band});
        end
    endtask
    task automatic s_fast;
        host_u.wr(16'hFE20, 8'h11);
        host_u.wr(16'hFE21, 8'h22);
        host_u.wr(16'hFE22, 8'h33);
        host_u.wr(16'hFE23, 8'h44);
        host_u.wr(16'hFE24, 8'h00);
        ov = 1'b1;
        step(2);
        chk("fast_mode", 16'h0000, {15'h0000, fm});
        host_u.wr(16'hFE24, 8'h80);
        step(1);
        chk("fast_mode", 16'h0001, {15'h0000, fm});
        chk("coef", 16'h3344, coef);
        ov = 1'b0;
        step(1);
        chk("fast_mode", 16'h0000, {15'h0000, fm});
        chk("coef", 16'h1122, coef);
        // band error with its enable clear must leave the normal filter in place
        be = 1'b1;
        step(2);
        chk("fast_mode", 16'h0000, {15'h0000, fm});
        be = 1'b0;
        host_u.wr(16'hFE24, 8'h0D);
        be = 1'b1;
        step(1);
        chk("fast_mode", 16'h0001, {15'h0000, fm});
        be = 1'b0;
        step(1);
        for (int i = 0; i < 3; i++) begin
            ht = 1'b1;
            step(1);
            ht = 1'b0;
            chk("fast_mode", {15'h0000, i < 2}, {15'h0000, fm});
            step(1);
        end
    endtask
    task automatic s_ss;
        host_u.wr(16'hFE24, 8'h02);
        ss = 1'b1;
        step(1);
        chk("fast_mode", 16'h0001, {15'h0000, fm});
        host_u.wr(16'hFE24, 8'h00);
        step(1);
        chk("fast_mode", 16'h0000, {15'h0000, fm});
        ss = 1'b0;
    endtask
    task automatic s_dither;
        host_u.wr(16'hFE1D, 8'h01);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            step(1);
            while (tick !== 1'b1 && n < 4000) begin
                step(1);
                n++;
            end
            if (n >= 4000) begin
                err_count++;
                close_out();
            end
        end
        chk("dither period", 16'h063F, 16'(n));
    endtask
    initial begin
        repeat (20) @(negedge mclk);
        rstn = 1'b1;
        s_regs();
        s_fields();
        s_fast();
        s_ss();
        s_dither();
        close_out();
    end
endmodule
